// >>> design/store_word_and_subtract_exec.v
// single-cycle execute stage for word stores and subtract-from forms
// assumes issue and exception inputs come from logic on I_CLK, valid
// in the same cycle as the instruction; results appear one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "sws_consts.vh"
module store_word_and_subtract_exec (
    // clock, reset, enable
    input wire I_CLK,
    input wire I_RESET,
    input wire i_CE,
    // instruction issue
    input wire i_INSN_VALID,
    input wire [31:0] i_INSN,
    input wire [31:0] i_BASE_VAL,
    input wire [31:0] i_INDEX_VAL,
    input wire [31:0] i_SRC_VAL,
    // reservation set by the reserving load
    input wire i_RESV_SET,
    // exception conditions from translation and debug
    input wire i_DTLB_MISS,
    input wire i_DSTORAGE_FAULT,
    input wire i_DADDR_CMP_HIT,
    input wire i_DVALUE_HIT,
    // register bus
    input wire [7:0] i_REG_ADDR,
    input wire [31:0] i_REG_WDATA,
    input wire i_REG_WR,
    input wire i_REG_RD,
    output reg [31:0] o_REG_RDATA,
    // data storage path
    output reg o_ST_VALID,
    output reg [31:0] o_ST_ADDR,
    output reg [31:0] o_ST_DATA,
    // register writeback
    output reg o_GPR_WE,
    output reg [4:0] o_GPR_ADDR,
    output reg [31:0] o_GPR_DATA,
    // completion and exceptions
    output reg o_DONE,
    output reg o_INVALID,
    output reg o_EXC_DTLB,
    output reg o_EXC_DSTORAGE,
    output reg o_EXC_ALIGN,
    output reg o_EXC_DEBUG,
    // flags and interrupt
    output reg [3:0] o_COND_FIELD,
    output reg o_RESV,
    output reg o_IRQ
);
    // byte reversal of a full word
    function [31:0] byte_rev;
        input [31:0] w;
        begin
            byte_rev = {w[7:0], w[15:8], w[23:16], w[31:24]};
        end
    endfunction

    // condition field from a signed result: lt, gt, eq, sticky
    function [3:0] cr_from_result;
        input [31:0] r;
        input so;
        begin
            cr_from_result = {r[31], (~r[31]) & (r != 32'h00000000),
                (r == 32'h00000000), so};
        end
    endfunction

    // decoded instruction fields
    wire [5:0] primary;
    wire [4:0] src_field;
    wire [4:0] base_field;
    wire [9:0] xo10;
    wire [8:0] xo9;
    wire oe_bit;
    wire rc_bit;
    assign primary = i_INSN[31:26];
    assign src_field = i_INSN[25:21];
    assign base_field = i_INSN[20:16];
    assign xo10 = i_INSN[10:1];
    assign xo9 = i_INSN[9:1];
    assign oe_bit = i_INSN[10];
    assign rc_bit = i_INSN[0];

    // instruction classes
    wire is_x;
    wire is_st_upd_d;
    wire is_st_rev;
    wire is_st_cond;
    wire is_st_upd_x;
    wire is_st_x;
    wire is_sub;
    wire is_subc;
    wire is_sube;
    wire is_store;
    wire is_subtract;
    wire is_update;
    assign is_x = (primary == `OP_PRIMARY_X);
    assign is_st_upd_d = (primary == `OP_STORE_WORD_UPD);
    assign is_st_rev = is_x && (xo10 == `XO_STORE_REV);
    assign is_st_cond = is_x && (xo10 == `XO_STORE_COND);
    assign is_st_upd_x = is_x && (xo10 == `XO_STORE_UPD_X);
    assign is_st_x = is_x && (xo10 == `XO_STORE_X);
    assign is_sub = is_x && (xo9 == `XO_SUB_FROM);
    assign is_subc = is_x && (xo9 == `XO_SUB_CARRY);
    assign is_sube = is_x && (xo9 == `XO_SUB_EXT);
    assign is_store = is_st_upd_d | is_st_rev | is_st_cond | is_st_upd_x | is_st_x;
    assign is_subtract = is_sub | is_subc | is_sube;
    assign is_update = is_st_upd_d | is_st_upd_x;

    // software-visible state
    reg [31:0] core_config0_r;
    reg [31:0] xer_r;
    reg [3:0] cond_r;
    reg resv_r;
    reg [`IRQ_WIDTH-1:0] irq_status_r;
    reg [`IRQ_WIDTH-1:0] irq_mask_r;

    // effective address
    wire [31:0] ea;
    wire misaligned;
    ea_former u_ea (
        .i_base_field(base_field),
        .i_base_val(i_BASE_VAL),
        .i_index_val(i_INDEX_VAL),
        .i_disp(i_INSN[15:0]),
        .i_use_disp(is_st_upd_d),
        .o_ea(ea),
        .o_misaligned(misaligned)
    );

    // subtract datapath; carry in is one except for the extended form
    wire [31:0] diff;
    wire diff_cout;
    wire diff_ovf;
    wire sub_cin;
    assign sub_cin = is_sube ? xer_r[`XER_CA_BIT] : 1'b1;
    sub_adder #(
        .W(32)
    ) u_sub (
        .i_a(i_BASE_VAL),
        .i_b(i_INDEX_VAL),
        .i_cin(sub_cin),
        .o_sum(diff),
        .o_cout(diff_cout),
        .o_ovf(diff_ovf)
    );

    // exception resolution for stores; translation miss outranks the rest
    reg exc_dtlb;
    reg exc_align;
    reg exc_dsi;
    reg exc_dbg;
    reg invalid;
    reg exc_any;
    always @* begin
        invalid = 1'b0;
        exc_dtlb = 1'b0;
        exc_align = 1'b0;
        exc_dsi = 1'b0;
        exc_dbg = 1'b0;
        if (is_update && (base_field == 5'h00)) begin
            invalid = 1'b1;
        end else if (is_st_cond && !rc_bit) begin
            // the conditional store's record bit is fixed at one
            invalid = 1'b1;
        end else if (is_store) begin
            if (i_DTLB_MISS) begin
                exc_dtlb = 1'b1;
            end else if (core_config0_r[`CFG_FORCE_ALIGN_BIT] && misaligned) begin
                exc_align = 1'b1;
            end else if (!is_st_cond || resv_r) begin
                // a failing conditional store never faults on storage or debug
                exc_dsi = i_DSTORAGE_FAULT;
                exc_dbg = ~i_DSTORAGE_FAULT & (i_DADDR_CMP_HIT | i_DVALUE_HIT);
            end
        end
        exc_any = exc_dtlb | exc_align | exc_dsi | exc_dbg;
    end

    // execute outcome
    wire go;
    wire recog;
    wire store_ok;
    wire cond_exec;
    wire cond_stored;
    assign go = i_CE && i_INSN_VALID;
    assign recog = is_store | is_subtract;
    assign store_ok = go && is_store && !invalid && !exc_any;
    assign cond_exec = store_ok && is_st_cond;
    assign cond_stored = cond_exec && resv_r;

    // register bus decode
    wire wr_cfg;
    wire wr_xer;
    wire wr_status;
    wire wr_mask;
    assign wr_cfg = i_REG_WR && (i_REG_ADDR == `REG_CORE_CONFIG0);
    assign wr_xer = i_REG_WR && (i_REG_ADDR == `REG_INT_EXCEPTION);
    assign wr_status = i_REG_WR && (i_REG_ADDR == `REG_IRQ_STATUS);
    assign wr_mask = i_REG_WR && (i_REG_ADDR == `REG_IRQ_MASK);

    // next flag state; instruction updates override a software write
    reg [31:0] xer_nxt;
    reg [3:0] cond_nxt;
    reg so_new;
    always @* begin
        xer_nxt = wr_xer ? i_REG_WDATA : xer_r;
        cond_nxt = cond_r;
        so_new = xer_nxt[`XER_SO_BIT];
        if (go && is_subtract) begin
            if (oe_bit) begin
                xer_nxt[`XER_OV_BIT] = diff_ovf;
                so_new = xer_nxt[`XER_SO_BIT] | diff_ovf;
                xer_nxt[`XER_SO_BIT] = so_new;
            end
            if (is_subc || is_sube) begin
                xer_nxt[`XER_CA_BIT] = diff_cout;
            end
            if (rc_bit) begin
                cond_nxt = cr_from_result(diff, so_new);
            end
        end
        if (cond_exec) begin
            cond_nxt = {2'b00, cond_stored, xer_r[`XER_SO_BIT]};
        end
    end

    // sticky interrupt events; a new event beats a same-cycle clear
    reg [`IRQ_WIDTH-1:0] irq_evt;
    reg [`IRQ_WIDTH-1:0] irq_status_nxt;
    always @* begin
        irq_evt = {`IRQ_WIDTH{1'b0}};
        irq_evt[`IRQ_STORE_DONE] = store_ok && (!is_st_cond || resv_r);
        irq_evt[`IRQ_COND_FAIL] = cond_exec && !resv_r;
        irq_evt[`IRQ_INVALID] = go && invalid;
        irq_evt[`IRQ_EXCEPTION] = go && exc_any;
        irq_status_nxt = irq_status_r;
        if (wr_status) begin
            irq_status_nxt = irq_status_r & ~i_REG_WDATA[`IRQ_WIDTH-1:0];
        end
        irq_status_nxt = irq_status_nxt | irq_evt;
    end

    // read data multiplexer, unmapped addresses read as zero
    reg [31:0] rdata_nxt;
    always @* begin
        rdata_nxt = 32'h00000000;
        if (i_REG_ADDR == `REG_CORE_CONFIG0) begin
            rdata_nxt = core_config0_r;
        end else if (i_REG_ADDR == `REG_INT_EXCEPTION) begin
            rdata_nxt = xer_r;
        end else if (i_REG_ADDR == `REG_COND_FIELD) begin
            rdata_nxt = {28'h0000000, cond_r};
        end else if (i_REG_ADDR == `REG_IRQ_STATUS) begin
            rdata_nxt = {{(32-`IRQ_WIDTH){1'b0}}, irq_status_r};
        end else if (i_REG_ADDR == `REG_IRQ_MASK) begin
            rdata_nxt = {{(32-`IRQ_WIDTH){1'b0}}, irq_mask_r};
        end else if (i_REG_ADDR == `REG_RESV_STATE) begin
            rdata_nxt = {31'h0, resv_r};
        end
    end

    // reservation: only the reserving load sets it, the store drops it
    // either way; a set in the same cycle wins so the event is not lost
    wire resv_nxt;
    assign resv_nxt = i_RESV_SET ? 1'b1 : (cond_exec ? 1'b0 : resv_r);

    // software-visible registers
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            core_config0_r <= `RST_CORE_CONFIG0;
            xer_r <= `RST_INT_EXCEPTION;
            cond_r <= `RST_COND_FIELD;
            resv_r <= 1'b0;
            irq_status_r <= `RST_IRQ;
            irq_mask_r <= `RST_IRQ;
            o_REG_RDATA <= 32'h00000000;
        end else if (i_CE) begin
            if (wr_cfg) begin
                core_config0_r <= i_REG_WDATA;
            end
            if (wr_mask) begin
                irq_mask_r <= i_REG_WDATA[`IRQ_WIDTH-1:0];
            end
            xer_r <= xer_nxt;
            cond_r <= cond_nxt;
            resv_r <= resv_nxt;
            irq_status_r <= irq_status_nxt;
            o_REG_RDATA <= i_REG_RD ? rdata_nxt : 32'h00000000;
        end
    end

    // storage request: one word per store, no split at this stage
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            o_ST_VALID <= 1'b0;
            o_ST_ADDR <= 32'h00000000;
            o_ST_DATA <= 32'h00000000;
        end else if (i_CE) begin
            o_ST_VALID <= store_ok && (!is_st_cond || resv_r);
            if (store_ok) begin
                o_ST_ADDR <= ea;
                // reversed relative to the page's own ordering, applied later
                o_ST_DATA <= is_st_rev ? byte_rev(i_SRC_VAL) : i_SRC_VAL;
            end
        end
    end

    // register writeback: subtract result or updated base address
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            o_GPR_WE <= 1'b0;
            o_GPR_ADDR <= 5'h00;
            o_GPR_DATA <= 32'h00000000;
        end else if (i_CE) begin
            o_GPR_WE <= 1'b0;
            if (go && is_subtract) begin
                o_GPR_WE <= 1'b1;
                o_GPR_ADDR <= src_field;
                o_GPR_DATA <= diff;
            end else if (store_ok && is_update) begin
                o_GPR_WE <= 1'b1;
                o_GPR_ADDR <= base_field;
                o_GPR_DATA <= ea;
            end
        end
    end

    // completion, exceptions and mirrored flags
    always @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            o_DONE <= 1'b0;
            o_INVALID <= 1'b0;
            o_EXC_DTLB <= 1'b0;
            o_EXC_DSTORAGE <= 1'b0;
            o_EXC_ALIGN <= 1'b0;
            o_EXC_DEBUG <= 1'b0;
            o_COND_FIELD <= `RST_COND_FIELD;
            o_RESV <= 1'b0;
            o_IRQ <= 1'b0;
        end else if (i_CE) begin
            o_DONE <= go && recog && !invalid && !exc_any;
            o_INVALID <= go && (invalid || !recog);
            o_EXC_DTLB <= go && exc_dtlb;
            o_EXC_DSTORAGE <= go && exc_dsi;
            o_EXC_ALIGN <= go && exc_align;
            o_EXC_DEBUG <= go && exc_dbg;
            // plain stores with record bit set leave the field untouched
            o_COND_FIELD <= cond_nxt;
            o_RESV <= resv_nxt;
            o_IRQ <= |(irq_status_nxt & (wr_mask ? i_REG_WDATA[`IRQ_WIDTH-1:0] : irq_mask_r));
        end
    end
endmodule
`default_nettype wire

// >>> design/sws_consts.vh
// constants for the word-store and subtract-from execute block
// assumes instructions arrive with the top bit of the word as instruction bit 0
// Contract
// - byte-reversed store swaps all four source bytes
// - address is index plus base, base zero if field zero
// - conditional store writes and clears reservation when held
// - conditional store without reservation writes nothing
// - conditional store sets condition field: 0,0,stored,sticky
// - only reserving load sets reservation; store clears it
// - no reservation: no storage or debug interrupt
// - data translation miss always raises its interrupt
// - forced alignment: misaligned conditional store raises alignment
// - displacement update store sign-extends sixteen-bit displacement
// - update stores write address to base; base zero invalid
// - plain indexed store writes word, alters no register
// - record bit on plain stores leaves condition field alone
// - subtract-from writes not base plus index plus one
// - record bit updates condition field; overflow bit updates flags
// - carrying subtract sets borrow flag from carry out
// - extended subtract adds borrow flag, updates it
`ifndef SWS_CONSTS_VH
`define SWS_CONSTS_VH

// opcodes
`define OP_PRIMARY_X 6'h1F
`define OP_STORE_WORD_UPD 6'h25
`define XO_STORE_REV 10'h296
`define XO_STORE_COND 10'h096
`define XO_STORE_UPD_X 10'h0B7
`define XO_STORE_X 10'h097
`define XO_SUB_FROM 9'h028
`define XO_SUB_CARRY 9'h008
`define XO_SUB_EXT 9'h088

// register offsets (byte addresses)
`define REG_CORE_CONFIG0 8'h00
`define REG_INT_EXCEPTION 8'h04
`define REG_COND_FIELD 8'h08
`define REG_IRQ_STATUS 8'h0C
`define REG_IRQ_MASK 8'h10
`define REG_RESV_STATE 8'h14

// field positions
`define CFG_FORCE_ALIGN_BIT 8
`define XER_SO_BIT 31
`define XER_OV_BIT 30
`define XER_CA_BIT 29
`define IRQ_STORE_DONE 0
`define IRQ_COND_FAIL 1
`define IRQ_INVALID 2
`define IRQ_EXCEPTION 3
`define IRQ_WIDTH 4

// reset values
`define RST_CORE_CONFIG0 32'h00000000
`define RST_INT_EXCEPTION 32'h00000000
`define RST_COND_FIELD 4'h0
`define RST_IRQ 4'h0

`endif

// >>> design/sub_adder.v
// carry-propagate three-input adder for the subtract-from family
// assumes purely combinational use inside the execute stage
`timescale 1ns/1ps
`default_nettype none
module sub_adder #(
    parameter W = 32
) (
    // operands
    input wire [W-1:0] i_a,
    input wire [W-1:0] i_b,
    input wire i_cin,
    // results
    output wire [W-1:0] o_sum,
    output wire o_cout,
    output wire o_ovf
);
    wire [W:0] full;
    wire [W-1:0] inv_a;

    // one's complement of the base operand plus index plus carry in
    assign inv_a = ~i_a;
    assign full = {1'b0, inv_a} + {1'b0, i_b} + {{W{1'b0}}, i_cin};
    assign o_sum = full[W-1:0];
    assign o_cout = full[W];
    // signed overflow: both addends agree in sign, result disagrees
    assign o_ovf = (inv_a[W-1] == i_b[W-1]) && (full[W-1] != i_b[W-1]);
endmodule
`default_nettype wire

// >>> design/ea_former.v
// effective address former shared by all store forms
// assumes operand values are already read from the register file
`timescale 1ns/1ps
`default_nettype none
module ea_former (
    // operands
    input wire [4:0] i_base_field,
    input wire [31:0] i_base_val,
    input wire [31:0] i_index_val,
    input wire [15:0] i_disp,
    input wire i_use_disp,
    // address
    output wire [31:0] o_ea,
    output wire o_misaligned
);
    wire [31:0] base;
    wire [31:0] offs;

    // base of zero when the field names register zero
    assign base = (i_base_field == 5'h00) ? 32'h00000000 : i_base_val;
    // displacement is sign-extended to the full word
    assign offs = i_use_disp ? {{16{i_disp[15]}}, i_disp} : i_index_val;
    assign o_ea = base + offs;
    assign o_misaligned = (o_ea[1:0] != 2'b00);
endmodule
`default_nettype wire

// >>> testbench/sws_store_sink.sv
// data storage path model standing behind the execute block
// assumes store requests are one-cycle pulses on the core clock
`timescale 1ns/1ps
`default_nettype none
module sws_store_sink (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // store request
    input wire logic st_valid,
    input wire logic [31:0] st_data,
    // observation
    output var int n_st,
    output var logic [31:0] last_data
);
    // accepts at once; a split access would show up as extra requests
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            n_st <= 0;
            last_data <= 32'h0;
        end else if (st_valid) begin
            n_st <= n_st + 1;
            last_data <= st_data;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/store_word_and_subtract_exec_props.sv
// concurrent checks on the word-store and subtract execute block
// assumes one clock domain and answers one edge after issue
`timescale 1ns/1ps
`default_nettype none
`include "sws_consts.vh"
module sws_exec_props (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // issue
    input wire logic i_CE,
    input wire logic i_INSN_VALID,
    input wire logic [31:0] i_INSN,
    input wire logic [31:0] i_BASE_VAL,
    input wire logic [31:0] i_INDEX_VAL,
    input wire logic [31:0] i_SRC_VAL,
    input wire logic i_RESV_SET,
    input wire logic i_DTLB_MISS,
    input wire logic i_DSTORAGE_FAULT,
    input wire logic i_DADDR_CMP_HIT,
    input wire logic i_DVALUE_HIT,
    // answers
    input wire logic o_ST_VALID,
    input wire logic [31:0] o_ST_ADDR,
    input wire logic [31:0] o_ST_DATA,
    input wire logic o_GPR_WE,
    input wire logic [4:0] o_GPR_ADDR,
    input wire logic [31:0] o_GPR_DATA,
    input wire logic o_DONE,
    input wire logic o_INVALID,
    input wire logic o_EXC_DTLB,
    input wire logic o_EXC_DSTORAGE,
    input wire logic o_EXC_DEBUG,
    input wire logic [3:0] o_COND_FIELD,
    input wire logic o_RESV
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // own decode of the issue cycle, independent of the design's decoder
    wire go = i_CE && i_INSN_VALID;
    wire xop = go && i_INSN[31:26] == `OP_PRIMARY_X;
    wire [31:0] ea = (i_INSN[20:16] == 5'h00 ? 32'h0 : i_BASE_VAL) + i_INDEX_VAL;
    wire hits = i_DSTORAGE_FAULT || i_DADDR_CMP_HIT || i_DVALUE_HIT;
    wire al = !i_DTLB_MISS && ea[1:0] == 2'b00;
    wire stcx = xop && i_INSN[10:1] == `XO_STORE_COND && i_INSN[0];
    wire upd0 = go && i_INSN[20:16] == 5'h00 && (i_INSN[31:26] == `OP_STORE_WORD_UPD
        || (xop && i_INSN[10:1] == `XO_STORE_UPD_X));
    wire subf = xop && i_INSN[9:1] == `XO_SUB_FROM && !i_DTLB_MISS && !hits;
    logic [31:0] ea_r, src_r, dif_r;
    logic [4:0] rt_r;
    // issue operands held for the answer one edge later
    always @(posedge I_CLK) begin
        ea_r <= ea;
        src_r <= i_SRC_VAL;
        dif_r <= ~i_BASE_VAL + i_INDEX_VAL + 32'h1;
        rt_r <= i_INSN[25:21];
    end
    sequence s_stored;
        o_ST_VALID && o_DONE && o_ST_ADDR == ea_r;
    endsequence
    property p_cond_ok;
        stcx && o_RESV && !i_RESV_SET && al && !hits |=> s_stored ##0 o_ST_DATA == src_r && !o_RESV;
    endproperty
    a_cond_ok: assert property (p_cond_ok) else $error("held store wrong");
    property p_cond_nowr;
        stcx && !o_RESV && !i_RESV_SET |=> !o_ST_VALID;
    endproperty
    a_cond_nowr: assert property (p_cond_nowr) else $error("store without hold");
    property p_cond_cr;
        stcx && al && !i_RESV_SET && !(o_RESV && hits) |=> o_COND_FIELD[3:1] == {2'b00, $past(o_RESV)};
    endproperty
    a_cond_cr: assert property (p_cond_cr) else $error("cond field wrong");
    property p_resv_set;
        $rose(o_RESV) |-> $past(i_RESV_SET);
    endproperty
    a_resv_set: assert property (p_resv_set) else $error("hold set by other");
    property p_no_dsi;
        stcx && !o_RESV && !i_RESV_SET && al |=> o_DONE && !o_EXC_DSTORAGE && !o_EXC_DEBUG;
    endproperty
    a_no_dsi: assert property (p_no_dsi) else $error("fault not suppressed");
    property p_tlb;
        stcx && i_DTLB_MISS |=> o_EXC_DTLB && !o_ST_VALID && !o_DONE;
    endproperty
    a_tlb: assert property (p_tlb) else $error("tlb miss lost");
    property p_upd_inv;
        upd0 |=> o_INVALID && !o_ST_VALID && !o_GPR_WE;
    endproperty
    a_upd_inv: assert property (p_upd_inv) else $error("update base zero taken");
    property p_subf;
        subf |=> o_GPR_WE && o_GPR_ADDR == rt_r && o_GPR_DATA == dif_r;
    endproperty
    a_subf: assert property (p_subf) else $error("subtract result wrong");
endmodule
bind store_word_and_subtract_exec sws_exec_props u_props (.I_CLK, .I_RESET, .i_CE,
    .i_INSN_VALID, .i_INSN, .i_BASE_VAL, .i_INDEX_VAL, .i_SRC_VAL, .i_RESV_SET, .i_DTLB_MISS,
    .i_DSTORAGE_FAULT, .i_DADDR_CMP_HIT, .i_DVALUE_HIT, .o_ST_VALID, .o_ST_ADDR, .o_ST_DATA,
    .o_GPR_WE, .o_GPR_ADDR, .o_GPR_DATA, .o_DONE, .o_INVALID, .o_EXC_DTLB, .o_EXC_DSTORAGE,
    .o_EXC_DEBUG, .o_COND_FIELD, .o_RESV);
`default_nettype wire

// >>> testbench/store_word_and_subtract_exec_test.sv
// self-checking bench for the word-store and subtract execute block
// assumes the design header on the include path and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "sws_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module store_word_and_subtract_exec_test;
    logic clk = 1'b0, rst = 1'b1, iv = 1'b0, rset = 1'b0, wstb = 1'b0, rstb = 1'b0;
    logic [31:0] ins = 32'h0, base = 32'h0, idx = 32'h0, src = 32'h0, wd = 32'h0, cst;
    logic [7:0] radr = 8'h00;
    logic [3:0] exc = 4'h0;
    wire [31:0] rdata, st_a, st_d, gd, last_d;
    wire [3:0] cf;
    wire [4:0] ga;
    wire st_v, gwe, done, inv, e_tlb, e_ds, e_al, e_db, resv, irq;
    wire [7:0] ev = {st_v, gwe, done, inv, e_tlb, e_ds, e_al, e_db};
    int n_st;
    int err_total = 0, samples_checked = 0, cyc = 0;
    store_word_and_subtract_exec u_dut (.I_CLK(clk), .I_RESET(rst), .i_CE(1'b1),
        .i_INSN_VALID(iv), .i_INSN(ins), .i_BASE_VAL(base), .i_INDEX_VAL(idx), .i_SRC_VAL(src),
        .i_RESV_SET(rset), .i_DTLB_MISS(exc[3]), .i_DSTORAGE_FAULT(exc[2]),
        .i_DADDR_CMP_HIT(exc[1]), .i_DVALUE_HIT(exc[0]), .i_REG_ADDR(radr), .i_REG_WDATA(wd),
        .i_REG_WR(wstb), .i_REG_RD(rstb), .o_REG_RDATA(rdata), .o_ST_VALID(st_v),
        .o_ST_ADDR(st_a), .o_ST_DATA(st_d), .o_GPR_WE(gwe), .o_GPR_ADDR(ga), .o_GPR_DATA(gd),
        .o_DONE(done), .o_INVALID(inv), .o_EXC_DTLB(e_tlb), .o_EXC_DSTORAGE(e_ds),
        .o_EXC_ALIGN(e_al), .o_EXC_DEBUG(e_db), .o_COND_FIELD(cf), .o_RESV(resv), .o_IRQ(irq));
    sws_store_sink u_sink (.clk(clk), .rst(rst), .st_valid(st_v), .st_data(st_d),
        .n_st(n_st), .last_data(last_d));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // hang guard: the whole sequence needs about a hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            test_done();
        end
    end
    function automatic logic [31:0] xf(input logic [4:0] s, a, input logic [9:0] xo,
        input logic rc);
        return {`OP_PRIMARY_X, s, a, 5'd2, xo, rc};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        radr <= a;
        wd <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        radr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic ex(input logic [31:0] w, b, x, s, input logic [3:0] e);
        @(posedge clk);
        ins <= w;
        base <= b;
        idx <= x;
        src <= s;
        exc <= e;
        iv <= 1'b1;
        @(posedge clk);
        iv <= 1'b0;
        exc <= 4'h0;
        #1;
    endtask
    task automatic hold;
        @(posedge clk);
        rset <= 1'b1;
        @(posedge clk);
        rset <= 1'b0;
        #1;
    endtask
    task automatic sb(input logic [8:0] xo, input logic [31:0] b, x, r, xr);
        ex(xf(5'd9, 5'd3, {1'b0, xo}, 1'b0), b, x, 32'h0, 4'h0);
        `CHK(gd, r)
        rd(8'h04, xr);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        cst = xf(5'd4, 5'd3, `XO_STORE_COND, 1'b1);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(8'h14, 32'h0);
        rd(8'h10, 32'h0);
        ex(cst, 32'h1000, 32'h20, 32'hCAFE_0001, 4'h7);
        `CHK({ev, cf}, {8'h20, 4'h0})
        wr(8'h04, 32'h8000_0000);
        hold();
        `CHK(resv, 1'b1)
        ex(cst, 32'h1000, 32'h20, 32'hCAFE_0001, 4'h0);
        `CHK({ev, st_a, st_d}, {8'hA0, 32'h1020, 32'hCAFE_0001})
        `CHK({cf, resv}, 5'b0011_0)
        wr(8'h00, 32'h100);
        `CHK(last_d, 32'hCAFE_0001)
        for (int k = 0; k < 2; k++) begin
            if (k == 1) hold();
            ex(cst, 32'h1000, 32'h22, 32'h0, 4'h0);
            `CHK(ev, 8'h02)
        end
        wr(8'h00, 32'h0);
        ex(cst, 32'h1000, 32'h20, 32'h0, 4'h8);
        `CHK({ev, resv}, {8'h08, 1'b1})
        ex(xf(5'd4, 5'd0, `XO_STORE_COND, 1'b1), 32'hFFFF_0000, 32'h40, 32'h0, 4'h0);
        `CHK({st_v, st_a}, {1'b1, 32'h40})
        ex(cst, 32'h1000, 32'h20, 32'h0, 4'h8);
        `CHK(ev, 8'h08)
        ex(xf(5'd4, 5'd3, `XO_STORE_REV, 1'b0), 32'h100, 32'h8, 32'h1122_3344, 4'h0);
        `CHK({ev, st_a, st_d}, {8'hA0, 32'h108, 32'h4433_2211})
        ex(xf(5'd4, 5'd3, `XO_STORE_X, 1'b1), 32'h200, 32'h4, 32'hA5A5_A5A5, 4'h0);
        `CHK({ev, st_d, cf}, {8'hA0, 32'hA5A5_A5A5, 4'h3})
        `CHK(last_d, 32'h4433_2211)
        // a plain store still takes storage and debug faults
        for (int k = 0; k < 2; k++) begin
            ex(xf(5'd4, 5'd3, `XO_STORE_X, 1'b0), 32'h200, 32'h4, 32'h0, k ? 4'h1 : 4'h4);
            `CHK(ev, k ? 8'h01 : 8'h04)
        end
        ex({`OP_STORE_WORD_UPD, 5'd6, 5'd7, 16'hFFF8}, 32'h2000, 32'h0, 32'h77, 4'h0);
        `CHK({ev, st_a, st_d, ga, gd}, {8'hE0, 32'h1FF8, 32'h77, 5'd7, 32'h1FF8})
        for (int k = 0; k < 2; k++) begin
            ex(k ? xf(5'd6, 5'd0, `XO_STORE_UPD_X, 1'b0) : {`OP_STORE_WORD_UPD, 5'd6, 5'd0,
                16'h4}, 32'h300, 32'h10, 32'h0, 4'h0);
            `CHK(ev, 8'h10)
        end
        ex(xf(5'd6, 5'd5, `XO_STORE_UPD_X, 1'b0), 32'h300, 32'h10, 32'h0, 4'h0);
        `CHK({ev, ga, gd}, {8'hE0, 5'd5, 32'h310})
        wr(8'h04, 32'h0);
        ex(xf(5'd9, 5'd3, {1'b0, `XO_SUB_FROM}, 1'b1), 32'h5, 32'h3, 32'h0, 4'h0);
        `CHK({gwe, ga, gd, cf}, {1'b1, 5'd9, 32'hFFFF_FFFE, 4'h8})
        ex(xf(5'd9, 5'd3, {1'b1, `XO_SUB_FROM}, 1'b1), 32'h1, 32'h8000_0000, 32'h0, 4'h0);
        `CHK({gd, cf}, {32'h7FFF_FFFF, 4'h5})
        rd(8'h04, 32'hC000_0000);
        wr(8'h04, 32'h0);
        sb(`XO_SUB_CARRY, 32'h1, 32'h0, 32'hFFFF_FFFF, 32'h0);
        sb(`XO_SUB_CARRY, 32'h0, 32'h0, 32'h0, 32'h2000_0000);
        sb(`XO_SUB_EXT, 32'h2, 32'h7, 32'h5, 32'h2000_0000);
        sb(`XO_SUB_EXT, 32'h7, 32'h2, 32'hFFFF_FFFB, 32'h0);
        sb(`XO_SUB_EXT, 32'h2, 32'h7, 32'h4, 32'h2000_0000);
        // sticky status, mask and the level output
        wr(8'h0C, 32'hF);
        wr(8'h10, 32'h2);
        `CHK(irq, 1'b0)
        ex(cst, 32'h1000, 32'h20, 32'h0, 4'h0);
        `CHK(irq, 1'b1)
        rd(8'h0C, 32'h2);
        wr(8'h10, 32'h0);
        `CHK(irq, 1'b0)
        wr(8'h10, 32'h2);
        `CHK(irq, 1'b1)
        wr(8'h0C, 32'h2);
        `CHK(irq, 1'b0)
        rd(8'h0C, 32'h0);
        rd(8'h40, 32'h0);
        `CHK(n_st, 6)
        test_done();
    end
endmodule
`default_nettype wire
